// ==== dv/gsos_host_mon.sv ====
`timescale 1ns/10ps
// Host side watching one status pin
module gsos_host_mon (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pin,
    output logic [7:0] pulses,
    output logic long_seen
);
    logic pin_reg;

    // Counts rising edges and notes any high lasting two cycles
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_reg <= 1'b0;
            pulses <= 8'h00;
            long_seen <= 1'b0;
        end else begin
            pin_reg <= pin;
            if (pin && !pin_reg) pulses <= pulses + 8'h01;
            if (pin && pin_reg) long_seen <= 1'b1;
        end
    end
endmodule

// ==== dv/tb_gsos_status_out.sv ====
`timescale 1ns/10ps
module tb_gsos_status_out;
    import gsos_pkg::*;
    logic clk;
    logic rst_b;
    logic [3:0] lvl;
    logic [3:0] hp_done;
    logic [7:0] bus_addr;
    logic [31:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
    logic [31:0] bus_rdata;
    logic [3:0] gpio_out;
    logic irq;
    logic [7:0] pulses;
    logic long_seen;
    logic [31:0] rd_data;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;

    gsos_status_out dut (.clk(clk), .rst_b(rst_b),
        .spk_shutdown_temp(lvl[0]), .spk_warn_temp(lvl[1]),
        .underclock_err(lvl[2]), .overclock_err(lvl[3]),
        .headphone_out_one_left_done(hp_done[0]),
        .headphone_out_one_right_done(hp_done[1]),
        .headphone_out_two_left_done(hp_done[2]),
        .headphone_out_two_right_done(hp_done[3]),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .gpio_out(gpio_out),
        .irq(irq));

    gsos_host_mon host (.clk(clk), .rst_b(rst_b), .pin(gpio_out[0]),
        .pulses(pulses), .long_seen(long_seen));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        rd_data = bus_rdata;
    endtask

    // Reset values and an unmapped read
    task automatic t_regs;
        rd(GSOS_FSEL_BASE);
        check(rd_data, {24'h0, GSOS_FSEL_RESET});
        rd(8'h3C);
        check(rd_data, 32'h0);
        rd(GSOS_MASK_ADDR);
        check(rd_data, {24'h0, GSOS_MASK_RESET});
        rd(GSOS_STATUS_ADDR);
        check(rd_data, {24'h0, GSOS_STATUS_RESET});
    endtask

    // Upper pin selects, an unhandled code drives low
    task automatic t_pins;
        wr(GSOS_FSEL_BASE + 8'h0C, {24'h0, GSOS_FN_UNDERCLK});
        wr(GSOS_FSEL_BASE + 8'h04, 32'h0000_002A);
        rd(GSOS_FSEL_BASE + 8'h0C);
        check(rd_data, {24'h0, GSOS_FN_UNDERCLK});
        @(posedge clk);
        lvl <= 4'hF;
        wait_cyc(3);
        check({28'h0, gpio_out}, 32'h8);
        @(posedge clk);
        lvl <= 4'h0;
        wr(GSOS_FSEL_BASE + 8'h0C, {24'h0, GSOS_FN_OFF});
        wr(GSOS_FSEL_BASE + 8'h04, {24'h0, GSOS_FN_OFF});
    endtask

    // Each headphone code gives one single-cycle pulse
    task automatic t_hp;
        logic [7:0] p;
        rd(GSOS_STATUS_ADDR);
        for (int k = 0; k < 4; k++) begin
            wr(GSOS_FSEL_BASE, {24'h0, GSOS_FN_HP1L + 8'(k)});
            wait_cyc(2);
            p = pulses;
            @(posedge clk);
            hp_done[k] <= 1'b1;
            wait_cyc(4);
            check({24'h0, pulses}, {24'h0, p + 8'h01});
            check({31'h0, long_seen}, 32'h0);
            rd(GSOS_STATUS_ADDR);
            check(rd_data, 32'h10 << k);
            @(posedge clk);
            hp_done[k] <= 1'b0;
        end
    endtask

    // Level codes follow their flag, other pins stay low
    task automatic t_levels;
        for (int k = 0; k < 4; k++) begin
            wr(GSOS_FSEL_BASE, {24'h0, GSOS_FN_SPK_SHUTDOWN + 8'(k)});
            @(posedge clk);
            lvl[k] <= 1'b1;
            wait_cyc(3);
            check({28'h0, gpio_out}, 32'h1);
            @(posedge clk);
            lvl[k] <= 1'b0;
            wait_cyc(3);
            check({28'h0, gpio_out}, 32'h0);
        end
    endtask

    // Masked event, unmask, read clears
    task automatic t_irq;
        rd(GSOS_STATUS_ADDR);
        wr(GSOS_MASK_ADDR, 32'h0);
        @(posedge clk);
        lvl[1] <= 1'b1;
        wait_cyc(3);
        check({31'h0, irq}, 32'h0);
        wr(GSOS_MASK_ADDR, 32'h2);
        wait_cyc(1);
        check({31'h0, irq}, 32'h1);
        rd(GSOS_RAW_ADDR);
        check(rd_data, 32'h2);
        wait_cyc(1);
        check(bus_rdata, 32'h0);
        rd(GSOS_STATUS_ADDR);
        check(rd_data, 32'h2);
        check({31'h0, irq}, 32'h0);
        @(posedge clk);
        lvl[1] <= 1'b0;
    endtask

    // A completion in the cycle of a status read survives the clear
    task automatic t_race;
        rd(GSOS_STATUS_ADDR);
        @(posedge clk);
        bus_rd <= 1'b1;
        bus_addr <= GSOS_STATUS_ADDR;
        hp_done[0] <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        check(bus_rdata, 32'h0);
        rd(GSOS_STATUS_ADDR);
        check(rd_data, 32'h10);
        @(posedge clk);
        hp_done[0] <= 1'b0;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            give_verdict;
        end
    end

    initial begin
        rst_b = 1'b0;
        lvl = 4'h0;
        hp_done = 4'h0;
        bus_addr = 8'h00;
        bus_wdata = 32'h0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_regs;
        t_pins;
        t_hp;
        t_levels;
        t_irq;
        t_race;
        give_verdict;
    end
endmodule

// ==== hdl/gsos_pin_sel.sv ====
`timescale 1ns/10ps
module gsos_pin_sel
    import gsos_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [GSOS_CODE_W-1:0] fsel,
    input wire logic [GSOS_NUM_LVL-1:0] level_flags,
    input wire logic [GSOS_NUM_HP-1:0] hp_pulse,
    output logic pin_out
);

    function automatic logic gsos_pick(
        input logic [GSOS_CODE_W-1:0] code,
        input logic [GSOS_NUM_LVL-1:0] lvl,
        input logic [GSOS_NUM_HP-1:0] hp
    );
        logic v;
        v = 1'b0;
        case (code)
            GSOS_FN_SPK_SHUTDOWN: v = lvl[GSOS_LVL_SHUTDOWN];
            GSOS_FN_SPK_WARN: v = lvl[GSOS_LVL_WARN];
            GSOS_FN_UNDERCLK: v = lvl[GSOS_LVL_UNDERCLK];
            GSOS_FN_OVERCLK: v = lvl[GSOS_LVL_OVERCLK];
            GSOS_FN_HP1L: v = hp[0];
            GSOS_FN_HP1R: v = hp[1];
            GSOS_FN_HP2L: v = hp[2];
            GSOS_FN_HP2R: v = hp[3];
            default: v = 1'b0;
        endcase
        return v;
    endfunction

    // Registered pin drive, low for codes not handled here
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_out <= 1'b0;
        end else begin
            pin_out <= gsos_pick(fsel, level_flags, hp_pulse);
        end
    end

endmodule

// ==== hdl/gsos_pkg.sv ====
package gsos_pkg;

    localparam int GSOS_CODE_W = 8;
    localparam int GSOS_ADDR_W = 8;
    localparam int GSOS_DATA_W = 32;
    localparam int GSOS_MAX_PINS = 8;
    localparam int GSOS_NUM_LVL = 4;
    localparam int GSOS_NUM_HP = 4;
    localparam int GSOS_EV_W = 8;

    // Pin function codes handled here
    localparam logic [7:0] GSOS_FN_OFF = 8'h00;
    localparam logic [7:0] GSOS_FN_SPK_SHUTDOWN = 8'h2B;
    localparam logic [7:0] GSOS_FN_SPK_WARN = 8'h2C;
    localparam logic [7:0] GSOS_FN_UNDERCLK = 8'h2D;
    localparam logic [7:0] GSOS_FN_OVERCLK = 8'h2E;
    localparam logic [7:0] GSOS_FN_HP1L = 8'h2F;
    localparam logic [7:0] GSOS_FN_HP1R = 8'h30;
    localparam logic [7:0] GSOS_FN_HP2L = 8'h31;
    localparam logic [7:0] GSOS_FN_HP2R = 8'h32;

    // Register byte addresses
    localparam logic [7:0] GSOS_FSEL_BASE = 8'h00;
    localparam logic [7:0] GSOS_STATUS_ADDR = 8'h20;
    localparam logic [7:0] GSOS_MASK_ADDR = 8'h24;
    localparam logic [7:0] GSOS_RAW_ADDR = 8'h28;

    // Reset values
    localparam logic [7:0] GSOS_FSEL_RESET = 8'h00;
    localparam logic [7:0] GSOS_MASK_RESET = 8'h00;
    localparam logic [7:0] GSOS_STATUS_RESET = 8'h00;

    // Level flag positions
    localparam int GSOS_LVL_SHUTDOWN = 0;
    localparam int GSOS_LVL_WARN = 1;
    localparam int GSOS_LVL_UNDERCLK = 2;
    localparam int GSOS_LVL_OVERCLK = 3;

    // Status and mask bit positions
    localparam int GSOS_EV_LVL_BASE = 0;
    localparam int GSOS_EV_HP_BASE = 4;

endpackage

// ==== hdl/gsos_status_out.sv ====
`timescale 1ns/10ps
module gsos_status_out
    import gsos_pkg::*;
#(
    parameter int NUM_PINS = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic spk_shutdown_temp,
    input wire logic spk_warn_temp,
    input wire logic underclock_err,
    input wire logic overclock_err,
    input wire logic headphone_out_one_left_done,
    input wire logic headphone_out_one_right_done,
    input wire logic headphone_out_two_left_done,
    input wire logic headphone_out_two_right_done,
    input wire logic [GSOS_ADDR_W-1:0] bus_addr,
    input wire logic [GSOS_DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [GSOS_DATA_W-1:0] bus_rdata,
    output logic [NUM_PINS-1:0] gpio_out,
    output logic irq
);

    logic [GSOS_CODE_W-1:0] fsel_reg [NUM_PINS];
    logic [GSOS_NUM_LVL-1:0] lvl;
    logic [GSOS_NUM_LVL-1:0] lvl_d_reg;
    logic [GSOS_NUM_HP-1:0] hp_done;
    logic [GSOS_NUM_HP-1:0] hp_done_d_reg;
    logic [GSOS_NUM_HP-1:0] hp_pulse;
    logic [GSOS_EV_W-1:0] ev;
    logic [GSOS_EV_W-1:0] status_reg;
    logic [GSOS_EV_W-1:0] status_next;
    logic [GSOS_EV_W-1:0] mask_reg;
    logic [GSOS_DATA_W-1:0] rdata_next;
    logic status_rd;

    // Index of a pin function register, or NUM_PINS when not one
    function automatic int gsos_fsel_idx(input logic [GSOS_ADDR_W-1:0] a);
        int idx;
        idx = NUM_PINS;
        for (int i = 0; i < NUM_PINS; i++) begin
            if (a == GSOS_FSEL_BASE + GSOS_ADDR_W'(4 * i)) begin
                idx = i;
            end
        end
        return idx;
    endfunction

    assign lvl = {overclock_err, underclock_err, spk_warn_temp,
                  spk_shutdown_temp};
    assign hp_done = {headphone_out_two_right_done,
                      headphone_out_two_left_done,
                      headphone_out_one_right_done,
                      headphone_out_one_left_done};

    // Edge history for completion pulses and event capture
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lvl_d_reg <= '0;
            hp_done_d_reg <= '0;
        end else begin
            lvl_d_reg <= lvl;
            hp_done_d_reg <= hp_done;
        end
    end

    // One-cycle pulse on each completed enable sequence
    assign hp_pulse = hp_done & ~hp_done_d_reg;
    assign ev = {hp_pulse, lvl & ~lvl_d_reg};

    // Pin function select registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                fsel_reg[i] <= GSOS_FSEL_RESET;
            end
        end else if (bus_wr && gsos_fsel_idx(bus_addr) < NUM_PINS) begin
            fsel_reg[gsos_fsel_idx(bus_addr)] <= bus_wdata[GSOS_CODE_W-1:0];
        end
    end

    // Interrupt mask
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_reg <= GSOS_MASK_RESET;
        end else if (bus_wr && bus_addr == GSOS_MASK_ADDR) begin
            mask_reg <= bus_wdata[GSOS_EV_W-1:0];
        end
    end

    // Sticky status, cleared by read, a new event wins over the clear
    assign status_rd = bus_rd && bus_addr == GSOS_STATUS_ADDR;

    always_comb begin
        status_next = status_reg;
        if (status_rd) begin
            status_next = '0;
        end
        status_next = status_next | ev;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_reg <= GSOS_STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    assign irq = |(status_reg & mask_reg);

    // Read data, zero for unmapped addresses
    always_comb begin
        rdata_next = '0;
        if (gsos_fsel_idx(bus_addr) < NUM_PINS) begin
            rdata_next[GSOS_CODE_W-1:0] = fsel_reg[gsos_fsel_idx(bus_addr)];
        end else if (bus_addr == GSOS_STATUS_ADDR) begin
            rdata_next[GSOS_EV_W-1:0] = status_reg;
        end else if (bus_addr == GSOS_MASK_ADDR) begin
            rdata_next[GSOS_EV_W-1:0] = mask_reg;
        end else if (bus_addr == GSOS_RAW_ADDR) begin
            rdata_next[GSOS_EV_W-1:0] = {hp_done, lvl};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_rdata <= '0;
        end else if (bus_rd) begin
            bus_rdata <= rdata_next;
        end else begin
            bus_rdata <= '0;
        end
    end

    // One selector per pin
    generate
        for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
            gsos_pin_sel u_sel (
                .clk(clk),
                .rst_b(rst_b),
                .fsel(fsel_reg[g]),
                .level_flags(lvl),
                .hp_pulse(hp_pulse),
                .pin_out(gpio_out[g])
            );
        end
    endgenerate

    // Checks on pin 0 and on the sticky status
    property p_shutdown;
        @(posedge clk) disable iff (!rst_b)
        (fsel_reg[0] == GSOS_FN_SPK_SHUTDOWN)
            |=> (gpio_out[0] == $past(spk_shutdown_temp));
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("Shutdown pin does not follow temperature flag");

    property p_warn;
        @(posedge clk) disable iff (!rst_b)
        (fsel_reg[0] == GSOS_FN_SPK_WARN && spk_warn_temp)
            |=> gpio_out[0];
    endproperty
    a_warn: assert property (p_warn)
        else $error("Warning pin low while warning flag high");

    property p_underclk;
        @(posedge clk) disable iff (!rst_b)
        (fsel_reg[0] == GSOS_FN_UNDERCLK && !underclock_err)
            |=> !gpio_out[0];
    endproperty
    a_underclk: assert property (p_underclk)
        else $error("Underclock pin high without error");

    property p_overclk;
        @(posedge clk) disable iff (!rst_b)
        (fsel_reg[0] == GSOS_FN_OVERCLK)[*2]
            |-> (gpio_out[0] == $past(overclock_err));
    endproperty
    a_overclk: assert property (p_overclk)
        else $error("Overclock pin does not follow error flag");

    property p_hp_pulse;
        @(posedge clk) disable iff (!rst_b)
        (fsel_reg[0] == GSOS_FN_HP2L && $rose(headphone_out_two_left_done))
            |=> gpio_out[0];
    endproperty
    a_hp_pulse: assert property (p_hp_pulse)
        else $error("No pulse after headphone sequence completion");

    property p_pulse_one;
        @(posedge clk) disable iff (!rst_b)
        (fsel_reg[0] >= GSOS_FN_HP1L && fsel_reg[0] <= GSOS_FN_HP2R
            && gpio_out[0] && $stable(fsel_reg[0]))
            |=> !gpio_out[0];
    endproperty
    a_pulse_one: assert property (p_pulse_one)
        else $error("Completion pulse longer than one cycle");

    property p_pulse_cause;
        @(posedge clk) disable iff (!rst_b)
        (fsel_reg[0] == GSOS_FN_HP1R && !headphone_out_one_right_done)
            |=> !gpio_out[0];
    endproperty
    a_pulse_cause: assert property (p_pulse_cause)
        else $error("Headphone pulse without completion");

    property p_status_sticky;
        @(posedge clk) disable iff (!rst_b)
        (hp_pulse[0] && status_rd) |=> status_reg[GSOS_EV_HP_BASE] ##1
            (status_reg[GSOS_EV_HP_BASE] || $past(status_rd));
    endproperty
    a_status_sticky: assert property (p_status_sticky)
        else $error("Status event lost against read clear");

endmodule
